/* rtl/decode_regs.svh */
`ifndef DECODE_REGS_SVH
`define DECODE_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets on the AXI4-Lite port
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_PC 8'h08
`define OFS_ACC 8'h0C
`define OFS_OPTION 8'h10
`define OFS_ICOUNT 8'h14

// Control register fields and reset value
`define CTRL_RUN_BIT 0
`define CTRL_WAKE_BIT 1
`define CTRL_RUN_RESET 1'b0

// Code option word fields
`define OPT_BRANCH_CYCLE_BIT 9
`define OPT_RESET 13'h1C00

// Core status byte fields
`define SR_C_BIT 0
`define SR_DC_BIT 1
`define SR_Z_BIT 2
`define SR_P_BIT 3
`define SR_T_BIT 4

// Register designators with special meaning
`define REG_PC_LOW 6'h02
`define REG_STATUS 6'h03

// Reset values
`define PC_RESET 13'h0000
`define PAGE_RESET 3'h0

// Timing: clocks per instruction cycle
`define CLKS_PER_ICYCLE 2

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* rtl/decode_pkg.sv */
package decode_pkg;

  typedef enum logic [3:0] {
    ALU_PASS, ALU_PASS_A, ALU_ZERO, ALU_SUB, ALU_ADD, ALU_OR, ALU_AND, ALU_XOR, ALU_COM, ALU_INC, ALU_DEC
  } alu_op_type;

  typedef enum logic [4:0] {
    K_NONE, K_SLEEP, K_WDTC, K_IOW, K_IOR, K_ENI, K_DISI, K_RETURN, K_INT_RETURN, K_RETURN_LIT,
    K_CALL, K_JUMP, K_BITCLR, K_BITSET, K_SKIPBC, K_SKIPBS, K_PAGE
  } kind_type;

  typedef enum {st_fetch, st_exec, st_extra_a, st_extra_b, st_sleep} state_type;

  typedef struct packed {
    kind_type kind;
    alu_op_type op;
    logic lit;
    logic to_reg;
    logic wr;
    logic fz;
    logic fc;
    logic skipz;
  } dec_type;

  typedef struct packed {
    logic [7:0] res;
    logic z;
    logic c;
    logic dc;
  } alu_out_type;

endpackage

/* rtl/alu_flags.sv */
module alu_flags (
  // Operation select
  input wire decode_pkg::alu_op_type i_op,
  // Operands: x is register or literal, y is the accumulator
  input wire logic [7:0] i_x,
  input wire logic [7:0] i_y,
  // Result and flags
  output decode_pkg::alu_out_type o_res
);
  import decode_pkg::*;

  logic [8:0] sum;
  logic [4:0] nib;

  // Subtraction adds the complement, so carry set means no borrow
  always_comb begin
    sum = 9'h000;
    nib = 5'h00;
    case (i_op)
      ALU_SUB: begin
        sum = 9'({1'b0, i_x} + {1'b0, ~i_y} + 9'h001);
        nib = 5'({1'b0, i_x[3:0]} + {1'b0, ~i_y[3:0]} + 5'h01);
      end
      ALU_ADD: begin
        sum = 9'({1'b0, i_x} + {1'b0, i_y});
        nib = 5'({1'b0, i_x[3:0]} + {1'b0, i_y[3:0]});
      end
      ALU_PASS: sum = {1'b0, i_x};
      ALU_PASS_A: sum = {1'b0, i_y};
      ALU_OR: sum = {1'b0, i_x | i_y};
      ALU_AND: sum = {1'b0, i_x & i_y};
      ALU_XOR: sum = {1'b0, i_x ^ i_y};
      ALU_COM: sum = {1'b0, ~i_x};
      ALU_INC: sum = {1'b0, 8'(i_x + 8'h01)};
      ALU_DEC: sum = {1'b0, 8'(i_x - 8'h01)};
      default: sum = 9'h000;
    endcase
  end

  assign o_res.res = sum[7:0];
  assign o_res.z = (sum[7:0] == 8'h00);
  assign o_res.c = sum[8];
  assign o_res.dc = nib[4];

endmodule

/* rtl/mcu_instruction_decode_timing.sv */
`include "decode_regs.svh"

module mcu_instruction_decode_timing #(
  parameter int STACK_DEPTH = 8,
  parameter int WATCHDOG_W = 8
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Program memory, one clock read latency
  output logic [12:0] o_pm_addr,
  input wire logic [12:0] i_pm_data,
  // Code option word, sampled once after reset
  input wire logic [12:0] i_code_option,
  // Core status
  output logic o_sleeping,
  output logic o_int_enable,
  // AXI4-Lite write
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready
);
  import decode_pkg::*;

  localparam int SPW = $clog2(STACK_DEPTH);

  ////////////////////////////////////////////////////////////////////////////////
  // Decode table

  function automatic dec_type mk(input kind_type kind, input alu_op_type op, input logic [5:0] f);
    dec_type d;
    d.kind = kind;
    d.op = op;
    {d.lit, d.to_reg, d.wr, d.fz, d.fc, d.skipz} = f;
    return d;
  endfunction

  // Flags vector order: literal, to register, write, zero, carry pair, skip on zero
  function automatic dec_type decode_fn(input logic [12:0] w);
    dec_type d;
    d = mk(K_NONE, ALU_PASS, 6'b000000);
    casez (w)
      // First match wins, so sleep must sit above the no-op group that overlaps it
      13'b0_0000_0000_0011: d = mk(K_SLEEP, ALU_PASS, 6'b000000);
      13'b0_0000_0000_00??: d = mk(K_NONE, ALU_PASS, 6'b000000);
      13'b0_0000_0000_0100: d = mk(K_WDTC, ALU_PASS, 6'b000000);
      13'b0_0000_0000_????: d = mk(K_IOW, ALU_PASS, 6'b000000);
      13'b0_0000_0001_0000: d = mk(K_ENI, ALU_PASS, 6'b000000);
      13'b0_0000_0001_0001: d = mk(K_DISI, ALU_PASS, 6'b000000);
      13'b0_0000_0001_0010: d = mk(K_RETURN, ALU_PASS, 6'b000000);
      13'b0_0000_0001_0011: d = mk(K_INT_RETURN, ALU_PASS, 6'b000000);
      13'b0_0000_0001_????: d = mk(K_IOR, ALU_PASS, 6'b000000);
      13'b0_0000_01??_????: d = mk(K_NONE, ALU_PASS_A, 6'b011000);
      13'b0_0000_1000_0000: d = mk(K_NONE, ALU_ZERO, 6'b001100);
      13'b0_0000_11??_????: d = mk(K_NONE, ALU_ZERO, 6'b011100);
      13'b0_0001_0???_????: d = mk(K_NONE, ALU_SUB, {1'b0, w[6], 4'b1110});
      13'b0_0001_1???_????: d = mk(K_NONE, ALU_DEC, {1'b0, w[6], 4'b1100});
      13'b0_0010_0???_????: d = mk(K_NONE, ALU_OR, {1'b0, w[6], 4'b1100});
      13'b0_0010_1???_????: d = mk(K_NONE, ALU_AND, {1'b0, w[6], 4'b1100});
      13'b0_0011_0???_????: d = mk(K_NONE, ALU_XOR, {1'b0, w[6], 4'b1100});
      13'b0_0011_1???_????: d = mk(K_NONE, ALU_ADD, {1'b0, w[6], 4'b1110});
      13'b0_0100_0???_????: d = mk(K_NONE, ALU_PASS, {1'b0, w[6], 4'b1100});
      13'b0_0100_1???_????: d = mk(K_NONE, ALU_COM, {1'b0, w[6], 4'b1100});
      13'b0_0101_0???_????: d = mk(K_NONE, ALU_INC, {1'b0, w[6], 4'b1100});
      13'b0_0101_1???_????: d = mk(K_NONE, ALU_DEC, {1'b0, w[6], 4'b1001});
      13'b0_0111_1???_????: d = mk(K_NONE, ALU_INC, {1'b0, w[6], 4'b1001});
      13'b0_100?_????_????: d = mk(K_BITCLR, ALU_PASS, 6'b000000);
      13'b0_101?_????_????: d = mk(K_BITSET, ALU_PASS, 6'b000000);
      13'b0_110?_????_????: d = mk(K_SKIPBC, ALU_PASS, 6'b000000);
      13'b0_111?_????_????: d = mk(K_SKIPBS, ALU_PASS, 6'b000000);
      13'b1_00??_????_????: d = mk(K_CALL, ALU_PASS, 6'b000000);
      13'b1_01??_????_????: d = mk(K_JUMP, ALU_PASS, 6'b000000);
      13'b1_1000_????_????: d = mk(K_NONE, ALU_PASS, 6'b101000);
      13'b1_1001_????_????: d = mk(K_NONE, ALU_OR, 6'b101100);
      13'b1_1010_????_????: d = mk(K_NONE, ALU_AND, 6'b101100);
      13'b1_1011_????_????: d = mk(K_NONE, ALU_XOR, 6'b101100);
      13'b1_1100_????_????: d = mk(K_RETURN_LIT, ALU_PASS, 6'b000000);
      13'b1_1101_????_????: d = mk(K_NONE, ALU_SUB, 6'b101110);
      13'b1_1111_????_????: d = mk(K_NONE, ALU_ADD, 6'b101110);
      13'b1_1110_1000_????: d = mk(K_PAGE, ALU_PASS, 6'b000000);
      default: d = mk(K_NONE, ALU_PASS, 6'b000000);
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State

  state_type state_q, state_d;
  logic [12:0] pc_q, opt_q;
  logic opt_valid_q, run_q, gie_q, sleeping_q;
  logic [7:0] acc_q;
  logic [2:0] page_q;
  logic c_q, dc_q, z_q, t_q, p_q;
  logic [WATCHDOG_W-1:0] watchdog_q;
  logic [31:0] icount_q;
  logic [SPW-1:0] sp_q;
  logic [12:0] stack_q [0:STACK_DEPTH-1];
  logic [7:0] rf_q [0:63];
  logic [7:0] ioc_q [0:15];

  ////////////////////////////////////////////////////////////////////////////////
  // Operand fields and execute datapath

  dec_type dec;
  alu_out_type alu;
  logic [5:0] r_sel;
  logic [2:0] b_sel;
  logic [7:0] k8, rd_val, status_byte, alu_x, bit_mask, wr_val;
  logic [9:0] k10;
  logic [12:0] pc_inc, stack_top, pc_next;
  logic [SPW-1:0] sp_m1;
  logic in_exec, is_bitop, reg_wr, acc_wr, pc_written, skip_taken, is_branch, two_cycle, icycle_tick;
  logic wake_req;

  assign dec = decode_fn(i_pm_data);
  assign r_sel = i_pm_data[5:0];
  assign b_sel = i_pm_data[8:6];
  assign k8 = i_pm_data[7:0];
  assign k10 = i_pm_data[9:0];
  assign in_exec = (state_q == st_exec);
  assign status_byte = {3'h0, t_q, p_q, z_q, dc_q, c_q};
  assign rd_val = (r_sel == `REG_PC_LOW) ? pc_q[7:0] : (r_sel == `REG_STATUS) ? status_byte : rf_q[r_sel];
  assign alu_x = dec.lit ? k8 : rd_val;

  alu_flags u_alu (
    .i_op(dec.op),
    .i_x(alu_x),
    .i_y(acc_q),
    .o_res(alu)
  );

  assign is_bitop = (dec.kind == K_BITCLR) || (dec.kind == K_BITSET);
  assign bit_mask = 8'(8'h01 << b_sel);
  assign wr_val = (dec.kind == K_BITSET) ? (rd_val | bit_mask) :
                  (dec.kind == K_BITCLR) ? (rd_val & ~bit_mask) : alu.res;
  assign reg_wr = in_exec && ((dec.wr && dec.to_reg) || is_bitop);
  assign acc_wr = in_exec && dec.wr && !dec.to_reg;
  assign pc_written = reg_wr && (r_sel == `REG_PC_LOW);
  assign skip_taken = in_exec && ((dec.skipz && alu.z) || ((dec.kind == K_SKIPBC) && !rd_val[b_sel]) ||
                      ((dec.kind == K_SKIPBS) && rd_val[b_sel]));
  assign is_branch = in_exec && (dec.kind inside {K_CALL, K_JUMP, K_RETURN, K_INT_RETURN, K_RETURN_LIT});
  // Plain instructions end in one cycle; PC writes, taken skips and selected branches take two
  assign two_cycle = pc_written || skip_taken ||
                     (is_branch && opt_q[`OPT_BRANCH_CYCLE_BIT]);

  assign pc_inc = 13'(pc_q + 13'h0001);
  assign sp_m1 = SPW'(sp_q - 1'b1);
  assign stack_top = stack_q[sp_m1];
  assign pc_next = (dec.kind inside {K_CALL, K_JUMP}) ? {page_q, k10} :
                   (dec.kind inside {K_RETURN, K_INT_RETURN, K_RETURN_LIT}) ? stack_top :
                   pc_written ? {pc_q[12:8], wr_val} :
                   skip_taken ? 13'(pc_q + 13'h0002) : pc_inc;
  assign icycle_tick = in_exec || (state_q == st_extra_b);

  ////////////////////////////////////////////////////////////////////////////////
  // Instruction cycle sequencing

  always_comb begin
    state_d = state_q;
    case (state_q)
      st_fetch: if (run_q && opt_valid_q) state_d = st_exec;
      st_exec: begin
        if (dec.kind == K_SLEEP) state_d = st_sleep;
        else if (two_cycle) state_d = st_extra_a;
        else state_d = st_fetch;
      end
      st_extra_a: state_d = st_extra_b;
      st_extra_b: state_d = st_fetch;
      st_sleep: if (wake_req) state_d = st_fetch;
      default: state_d = st_fetch;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      state_q <= st_fetch;
      sleeping_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sleeping_q <= (state_d == st_sleep);
    end
  end

  // Option word is latched once after release; nothing in the core can write it
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      opt_q <= `OPT_RESET;
      opt_valid_q <= 1'b0;
    end else if (!opt_valid_q) begin
      opt_q <= i_code_option;
      opt_valid_q <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      pc_q <= `PC_RESET;
      sp_q <= '0;
      page_q <= `PAGE_RESET;
    end else if (in_exec) begin
      pc_q <= pc_next;
      if (dec.kind == K_CALL) sp_q <= SPW'(sp_q + 1'b1);
      else if (dec.kind inside {K_RETURN, K_INT_RETURN, K_RETURN_LIT}) sp_q <= sp_m1;
      if (dec.kind == K_PAGE) page_q <= i_pm_data[2:0];
    end
  end

  // Data storage carries no reset; software initialises it
  always_ff @(posedge i_core_clk) begin
    if (in_exec && dec.kind == K_CALL) stack_q[sp_q] <= pc_inc;
    if (reg_wr && r_sel != `REG_PC_LOW && r_sel != `REG_STATUS) rf_q[r_sel] <= wr_val;
    if (in_exec && dec.kind == K_IOW) ioc_q[r_sel[3:0]] <= acc_q;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) acc_q <= 8'h00;
    else if (acc_wr) acc_q <= alu.res;
    else if (in_exec && dec.kind == K_IOR) acc_q <= ioc_q[r_sel[3:0]];
    else if (in_exec && dec.kind == K_RETURN_LIT) acc_q <= k8;
  end

  // Later assignments win: flag updates from the ALU override a direct status write
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      {c_q, dc_q, z_q} <= 3'h0;
      {t_q, p_q} <= 2'h3;
    end else begin
      if (reg_wr && r_sel == `REG_STATUS) begin
        c_q <= wr_val[`SR_C_BIT];
        dc_q <= wr_val[`SR_DC_BIT];
        z_q <= wr_val[`SR_Z_BIT];
      end
      if (in_exec && dec.fz) z_q <= alu.z;
      if (in_exec && dec.fc) begin
        c_q <= alu.c;
        dc_q <= alu.dc;
      end
      if (in_exec && dec.kind == K_SLEEP) {t_q, p_q} <= 2'h2;
      if (in_exec && dec.kind == K_WDTC) {t_q, p_q} <= 2'h3;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      gie_q <= 1'b0;
      watchdog_q <= '0;
      icount_q <= 32'h0000_0000;
    end else begin
      if (in_exec && (dec.kind inside {K_ENI, K_INT_RETURN})) gie_q <= 1'b1;
      else if (in_exec && dec.kind == K_DISI) gie_q <= 1'b0;
      if (in_exec && (dec.kind inside {K_SLEEP, K_WDTC})) watchdog_q <= '0;
      else if (icycle_tick) watchdog_q <= WATCHDOG_W'(watchdog_q + 1'b1);
      if (icycle_tick) icount_q <= 32'(icount_q + 32'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  logic aw_full_q, w_full_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic do_write, wr_hit_ctrl, wr_ok, rd_ok;
  logic [7:0] ar_word;
  logic [31:0] rd_word;

  assign do_write = aw_full_q && w_full_q && !bvalid_q;
  assign wr_hit_ctrl = ({aw_addr_q[7:2], 2'b00} == `OFS_CTRL);
  assign wr_ok = wr_hit_ctrl;
  assign wake_req = do_write && wr_hit_ctrl && w_strb_q[0] && w_data_q[`CTRL_WAKE_BIT];
  assign ar_word = {i_s_axi_araddr[7:2], 2'b00};
  assign rd_ok = (ar_word <= `OFS_ICOUNT);
  assign rd_word = (ar_word == `OFS_CTRL) ? {31'h0, run_q} :
                   (ar_word == `OFS_STATUS) ? {22'h0, sleeping_q, gie_q, status_byte} :
                   (ar_word == `OFS_PC) ? {19'h0, pc_q} :
                   (ar_word == `OFS_ACC) ? {24'h0, acc_q} :
                   (ar_word == `OFS_OPTION) ? {19'h0, opt_q} :
                   (ar_word == `OFS_ICOUNT) ? icount_q : 32'h0000_0000;

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      {aw_full_q, w_full_q, bvalid_q} <= 3'h0;
      {awready_q, wready_q} <= 2'h3;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bresp_q <= `RESP_OKAY;
      run_q <= `CTRL_RUN_RESET;
    end else begin
      if (i_s_axi_awvalid && awready_q) begin
        aw_addr_q <= i_s_axi_awaddr;
        aw_full_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (i_s_axi_wvalid && wready_q) begin
        w_data_q <= i_s_axi_wdata;
        w_strb_q <= i_s_axi_wstrb;
        w_full_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (do_write) begin
        {aw_full_q, w_full_q} <= 2'h0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        if (wr_hit_ctrl && w_strb_q[0]) run_q <= w_data_q[`CTRL_RUN_BIT];
      end
      if (bvalid_q && i_s_axi_bready) begin
        bvalid_q <= 1'b0;
        {awready_q, wready_q} <= 2'h3;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `RESP_OKAY;
    end else if (i_s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_q && i_s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign o_pm_addr = pc_q;
  assign o_sleeping = sleeping_q;
  assign o_int_enable = gie_q;
  assign o_s_axi_awready = awready_q;
  assign o_s_axi_wready = wready_q;
  assign o_s_axi_bvalid = bvalid_q;
  assign o_s_axi_bresp = bresp_q;
  assign o_s_axi_arready = arready_q;
  assign o_s_axi_rvalid = rvalid_q;
  assign o_s_axi_rdata = rdata_q;
  assign o_s_axi_rresp = rresp_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  a_fetch_to_exec: assert property (
    state_q == st_fetch && run_q && opt_valid_q |=> state_q == st_exec) else $error("fetch did not reach execute");
  a_plain_single_cycle: assert property (
    in_exec && !two_cycle && dec.kind != K_SLEEP |=> state_q == st_fetch) else $error("plain op not single cycle");
  a_pc_write_two: assert property (
    pc_written |=> state_q == st_extra_a ##1 state_q == st_extra_b ##1 state_q == st_fetch)
    else $error("pc write not two cycles");
  a_skip_two_cycle: assert property (
    skip_taken |=> state_q == st_extra_a && pc_q == 13'($past(pc_q) + 13'h0002)) else $error("skip timing wrong");
  a_branch_cycle_sel: assert property (
    is_branch |=> (state_q == st_extra_a) == opt_q[`OPT_BRANCH_CYCLE_BIT]) else $error("branch cycle select ignored");
  a_option_hold: assert property (
    opt_valid_q && $past(opt_valid_q) |-> $stable(opt_q)) else $error("option word changed");
  a_bitop_single_bit: assert property (
    in_exec && is_bitop |-> ((wr_val ^ rd_val) & ~bit_mask) == 8'h00 &&
    wr_val[b_sel] == (dec.kind == K_BITSET)) else $error("bit op touched wrong bit");
  a_jump_target: assert property (
    in_exec && dec.kind == K_JUMP |=> pc_q == {$past(page_q), $past(k10)}) else $error("jump target wrong");
  a_sleep_flags: assert property (
    in_exec && dec.kind == K_SLEEP |=> o_sleeping && t_q && !p_q && watchdog_q == '0) else $error("sleep effects wrong");
  a_interrupt_return_op_return: assert property (
    in_exec && dec.kind == K_INT_RETURN |=> o_int_enable && pc_q == $past(stack_top) && $stable({z_q, c_q, dc_q}))
    else $error("interrupt return wrong");
  a_skipz_flags: assert property (
    in_exec && dec.skipz && r_sel != `REG_STATUS |=> $stable({z_q, c_q, dc_q})) else $error("skip op changed flags");
  a_carry_untouched: assert property (
    in_exec && !dec.fc && !(reg_wr && r_sel == `REG_STATUS) |=> $stable(c_q)) else $error("carry changed");

  c_skip_taken: cover property (skip_taken);
  c_pc_written: cover property (pc_written);
  c_long_branch: cover property (is_branch && opt_q[`OPT_BRANCH_CYCLE_BIT]);
  c_sleep_wake: cover property (state_q == st_sleep ##1 state_q == st_fetch);

endmodule

/* tb/prog_mem_model.sv */
module prog_mem_model (
  // Clock
  input wire logic i_clk,
  // Fetch address and instruction word
  input wire logic [12:0] i_addr,
  output logic [12:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [12:0] mem [16];
  // Words past the image toggle, so a stray fetch never looks like a clean word
  always_ff @(posedge i_clk) begin
    o_data <= (i_addr < 13'h0010) ? mem[i_addr[3:0]] : ~o_data;
  end
endmodule

/* tb/tb_top.sv */
`include "decode_regs.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [12:0] pm_addr, pm_data;
  logic [12:0] code_option = 13'h1C00;
  logic sleeping, int_enable;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  // Load 1, store, taken decrement-skip, jump, load 9, write PC low, sleep
  localparam logic [12:0] PROG [10] = '{13'h1801, 13'h0050, 13'h05D0, 13'h1405, 13'h1407,
    13'h0003, 13'h0000, 13'h1809, 13'h0042, 13'h0003};

  mcu_instruction_decode_timing dut_u (.i_core_clk(core_clk), .i_rstn(rstn), .o_pm_addr(pm_addr),
    .i_pm_data(pm_data), .i_code_option(code_option), .o_sleeping(sleeping), .o_int_enable(int_enable),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready));

  prog_mem_model pm_u (.i_clk(core_clk), .i_addr(pm_addr), .o_data(pm_data));

  initial begin
    forever #10 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic axi_write(input logic [7:0] addr, input logic [31:0] data, output logic [1:0] resp);
    awaddr <= addr;
    wdata <= data;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic axi_read(input logic [7:0] addr, output logic [31:0] data, output logic [1:0] resp);
    araddr <= addr;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    data = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge core_clk);
  endtask

  // Option word is only taken at reset, so each timing mode needs its own run
  task automatic run_prog(input logic [12:0] opt, input logic [31:0] exp_cycles);
    logic [1:0] r;
    logic [31:0] d;
    code_option <= opt;
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    axi_write(`OFS_CTRL, 32'h00000001, r);
    check("ctrl bresp", `RESP_OKAY, r);
    for (int i = 0; i < 200 && sleeping !== 1'b1; i++) @(posedge core_clk);
    check("sleeping", 32'h00000001, sleeping);
    check("int enable", 32'h00000000, int_enable);
    axi_read(`OFS_ICOUNT, d, r);
    check("cycle count", exp_cycles, d);
    axi_read(`OFS_ACC, d, r);
    check("acc", 32'h00000009, d);
    axi_read(`OFS_STATUS, d, r);
    check("status", 32'h00000210, d & 32'h00000318);
    axi_read(`OFS_OPTION, d, r);
    check("option", {19'h00000, opt}, d);
    axi_write(`OFS_OPTION, 32'h00000000, r);
    check("option wr bresp", `RESP_SLVERR, r);
    axi_read(`OFS_OPTION, d, r);
    check("option kept", {19'h00000, opt}, d);
    axi_read(8'h18, d, r);
    check("unmapped rresp", `RESP_SLVERR, r);
    check("unmapped rdata", 32'h00000000, d);
    $display("Test with option %h done, mismatches so far %0d", opt, num_errors);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      stop_test();
    end
  end

  initial begin
    for (int i = 0; i < 16; i++) pm_u.mem[i] = (i < 10) ? PROG[i] : 13'h0000;
    run_prog(13'h1C00, 32'h00000009);
    run_prog(13'h1E00, 32'h0000000A);
    stop_test();
  end
endmodule
